// file: verilog/t16d_top.sv
// 16-bit timer data registers, capture, compare and irq mask block
//
// Operation
// - each 16-bit value is a byte pair: bits 7:0 at the base, 15:8 at base plus one.
// - one shared 8-bit high-byte latch carries the high half of every 16-bit access.
// - the counter value can be read and written through its two byte locations.
// - a counter write suppresses compare matches on the following timer tick.
// - a capture event loads the current counter into the capture register.
// - in the top-from-capture modes the capture register is the counter top.
// - each compare register is compared with the counter on every timer tick.
// - a match on B serves both the interrupt path and the waveform output; a match on A drives only the waveform output.
// - capture irq is requested while mask bit 5, global enable and flag are set.
// - match-B irq is requested while mask bit 2, global enable and flag are set.
// - the capture flag sets on capture or on top in capture-top mode, clears on ack or write of one.
// - a match flag sets two cycles after the equality tick, one after the match strobe; a forced compare never sets it.
// - edge select zero is falling, one is rising; the filter wants four equal samples.
// - in capture-top modes the capture pin is disconnected and capture is off.
`timescale 1ns/1ps
`default_nettype none
`include "t16d_cfg.svh"

module t16d_top
  import t16d_pkg::*;
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // cpu byte bus
  input wire logic [7:0] IO_ADDR,
  input wire logic [7:0] IO_WDATA,
  input wire logic IO_WR,
  input wire logic IO_RD,
  output logic [7:0] IO_RDATA,
  // timer control from the rest of the unit
  input wire logic TIMER_TICK,
  input wire logic [3:0] WAVEFORM_MODE_SELECT,
  input wire logic CAPTURE_EDGE_SELECT,
  input wire logic CAPTURE_NOISE_FILTER_ENABLE,
  input wire logic CAPTURE_FROM_COMPARATOR,
  input wire logic GLOBAL_IRQ_ENABLE,
  // capture sources
  input wire logic CAPTURE_INPUT_PIN,
  input wire logic COMPARATOR_OUT,
  // flag clearing
  input wire logic CAPTURE_FLAG_CLEAR,
  input wire logic MATCH_B_FLAG_CLEAR,
  input wire logic CAPTURE_IRQ_ACK,
  input wire logic MATCH_B_IRQ_ACK,
  // match strobes to the waveform units
  output logic WAVEFORM_MATCH_A,
  output logic WAVEFORM_MATCH_B,
  // flags and interrupt requests
  output logic CAPTURE_FLAG,
  output logic MATCH_B_FLAG,
  output logic CAPTURE_IRQ_REQ,
  output logic MATCH_B_IRQ_REQ
);

  // =====================================================================
  // state
  t16d_top_st_t st_ff;
  t16d_top_st_t nxt_st;

  t16d_sel_t sel;
  logic sel_hi;
  logic sel_mask;
  logic [15:0] sel_val;
  logic cap_is_top;
  logic at_top;
  logic cap_evt_raw;
  logic cap_evt;
  logic [1:0] match;
  logic [15:0] cmp_val [2];

  // =====================================================================
  // capture input conditioning
  t16d_capt u_capt (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .pin(CAPTURE_INPUT_PIN),
    .acmp(COMPARATOR_OUT),
    .src_sel(CAPTURE_FROM_COMPARATOR),
    .edge_sel(CAPTURE_EDGE_SELECT),
    .filt_en(CAPTURE_NOISE_FILTER_ENABLE),
    .evt(cap_evt_raw)
  );

  // capture-top modes: 8, 10, 12, 14
  assign cap_is_top = WAVEFORM_MODE_SELECT[`T16D_BIT_WGM_HI] &
                      ~WAVEFORM_MODE_SELECT[`T16D_BIT_WGM_LO];
  // pin is cut off while the capture register serves as top
  assign cap_evt = cap_evt_raw & ~cap_is_top;
  assign at_top = cap_is_top & (st_ff.cnt == st_ff.cap);

  // =====================================================================
  // compare units
  assign cmp_val[0] = st_ff.cmp_a;
  assign cmp_val[1] = st_ff.cmp_b;

  generate
    for (genvar i = 0; i < 2; i++) begin : g_cmp
      t16d_cmp u_cmp (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .tick(TIMER_TICK),
        .block(st_ff.block),
        .cnt(st_ff.cnt),
        .cmp_val(cmp_val[i]),
        .match(match[i])
      );
    end
  endgenerate

  // =====================================================================
  // address decode
  always_comb begin
    sel = T16D_SEL_NONE;
    sel_hi = 1'b0;
    sel_mask = 1'b0;
    if (IO_ADDR == `T16D_OFF_MASK) begin
      sel_mask = 1'b1;
    end else if (IO_ADDR == `T16D_OFF_CNT) begin
      sel = T16D_SEL_CNT;
    end else if (IO_ADDR == `T16D_OFF_CNT + `T16D_HI_STEP) begin
      sel = T16D_SEL_CNT;
      sel_hi = 1'b1;
    end else if (IO_ADDR == `T16D_OFF_CAP) begin
      sel = T16D_SEL_CAP;
    end else if (IO_ADDR == `T16D_OFF_CAP + `T16D_HI_STEP) begin
      sel = T16D_SEL_CAP;
      sel_hi = 1'b1;
    end else if (IO_ADDR == `T16D_OFF_CMPA) begin
      sel = T16D_SEL_CMPA;
    end else if (IO_ADDR == `T16D_OFF_CMPA + `T16D_HI_STEP) begin
      sel = T16D_SEL_CMPA;
      sel_hi = 1'b1;
    end else if (IO_ADDR == `T16D_OFF_CMPB) begin
      sel = T16D_SEL_CMPB;
    end else if (IO_ADDR == `T16D_OFF_CMPB + `T16D_HI_STEP) begin
      sel = T16D_SEL_CMPB;
      sel_hi = 1'b1;
    end
  end

  always_comb begin
    case (sel)
      T16D_SEL_CNT: begin
        sel_val = st_ff.cnt;
      end
      T16D_SEL_CAP: begin
        sel_val = st_ff.cap;
      end
      T16D_SEL_CMPA: begin
        sel_val = st_ff.cmp_a;
      end
      T16D_SEL_CMPB: begin
        sel_val = st_ff.cmp_b;
      end
      default: begin
        sel_val = `T16D_RST_WORD;
      end
    endcase
  end

  // =====================================================================
  // next state
  always_comb begin
    nxt_st = st_ff;

    // counter advances on each tick; wraps at top in capture-top modes
    if (TIMER_TICK) begin
      nxt_st.block = 1'b0;
      if (at_top) begin
        nxt_st.cnt = `T16D_RST_WORD;
      end else begin
        nxt_st.cnt = 16'(st_ff.cnt + 16'h0001);
      end
    end

    // cpu writes: high bytes park in the shared latch
    if (IO_WR) begin
      if (sel_mask) begin
        nxt_st.cap_ie = IO_WDATA[`T16D_BIT_CAP_IE];
        nxt_st.mb_ie = IO_WDATA[`T16D_BIT_MB_IE];
      end else if (sel != T16D_SEL_NONE && sel_hi) begin
        nxt_st.temp = IO_WDATA;
      end else if (sel == T16D_SEL_CNT) begin
        // cpu write beats the tick increment and blocks the next match
        nxt_st.cnt = {st_ff.temp, IO_WDATA};
        nxt_st.block = 1'b1;
      end else if (sel == T16D_SEL_CAP) begin
        nxt_st.cap = {st_ff.temp, IO_WDATA};
      end else if (sel == T16D_SEL_CMPA) begin
        nxt_st.cmp_a = {st_ff.temp, IO_WDATA};
      end else if (sel == T16D_SEL_CMPB) begin
        nxt_st.cmp_b = {st_ff.temp, IO_WDATA};
      end
    end

    // hardware capture wins over a cpu write in the same cycle
    if (cap_evt) begin
      nxt_st.cap = st_ff.cnt;
    end

    // cpu reads: data registered, valid the cycle after the strobe
    if (IO_RD) begin
      if (sel_mask) begin
        nxt_st.rdata = `T16D_RST_BYTE;
        nxt_st.rdata[`T16D_BIT_CAP_IE] = st_ff.cap_ie;
        nxt_st.rdata[`T16D_BIT_MB_IE] = st_ff.mb_ie;
      end else if (sel != T16D_SEL_NONE && sel_hi) begin
        nxt_st.rdata = st_ff.temp;
      end else if (sel != T16D_SEL_NONE) begin
        nxt_st.rdata = sel_val[7:0];
        nxt_st.temp = sel_val[15:8];
      end else begin
        nxt_st.rdata = `T16D_RST_BYTE;
      end
    end

    // flags: a set in the clearing cycle wins
    nxt_st.cap_flag = (st_ff.cap_flag & ~(CAPTURE_IRQ_ACK | CAPTURE_FLAG_CLEAR)) |
                      cap_evt | (TIMER_TICK & at_top);
    // match strobe already lags equality by one cycle; no forced path here
    nxt_st.mb_flag = (st_ff.mb_flag & ~(MATCH_B_IRQ_ACK | MATCH_B_FLAG_CLEAR)) |
                     match[1];

    // requests follow the flags one cycle later
    nxt_st.cap_irq = st_ff.cap_ie & GLOBAL_IRQ_ENABLE & st_ff.cap_flag;
    nxt_st.mb_irq = st_ff.mb_ie & GLOBAL_IRQ_ENABLE & st_ff.mb_flag;
  end

  // =====================================================================
  // state register
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // =====================================================================
  // outputs
  assign IO_RDATA = st_ff.rdata;
  assign WAVEFORM_MATCH_A = match[0];
  assign WAVEFORM_MATCH_B = match[1];
  assign CAPTURE_FLAG = st_ff.cap_flag;
  assign MATCH_B_FLAG = st_ff.mb_flag;
  assign CAPTURE_IRQ_REQ = st_ff.cap_irq;
  assign MATCH_B_IRQ_REQ = st_ff.mb_irq;

endmodule // t16d_top
`default_nettype wire

// file: shared/t16d_cfg.svh
// offsets, field positions and reset values of the 16-bit timer data block
`ifndef T16D_CFG_SVH
`define T16D_CFG_SVH

// =====================================================================
// register offsets (low byte; high byte sits one above)
`define T16D_OFF_MASK 8'h6f
`define T16D_OFF_CNT 8'h84
`define T16D_OFF_CAP 8'h86
`define T16D_OFF_CMPA 8'h88
`define T16D_OFF_CMPB 8'h8a
`define T16D_HI_STEP 8'h01

// =====================================================================
// interrupt mask fields
`define T16D_BIT_CAP_IE 5
`define T16D_BIT_MB_IE 2

// =====================================================================
// waveform mode fields: capture value is top when bit 3 set, bit 0 clear
`define T16D_BIT_WGM_HI 3
`define T16D_BIT_WGM_LO 0

// =====================================================================
// reset values and capture filter
`define T16D_RST_WORD 16'h0000
`define T16D_RST_BYTE 8'h00
`define T16D_FILT_LEN 4

`endif

// file: shared/t16d_pkg.sv
// types shared by the 16-bit timer data block
package t16d_pkg;

  // =====================================================================
  // which 16-bit register a bus address selects
  typedef enum logic [2:0] {
    T16D_SEL_NONE,
    T16D_SEL_CNT,
    T16D_SEL_CAP,
    T16D_SEL_CMPA,
    T16D_SEL_CMPB
  } t16d_sel_t;

  // =====================================================================
  // state of the top module
  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] cap;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [7:0] temp;
    logic [7:0] rdata;
    logic cap_ie;
    logic mb_ie;
    logic cap_flag;
    logic mb_flag;
    logic cap_irq;
    logic mb_irq;
    logic block;
  } t16d_top_st_t;

  // state of the capture input conditioner
  typedef struct packed {
    logic [3:0] hist;
    logic filt;
    logic prev;
    logic evt;
  } t16d_capt_st_t;

  // state of one compare unit
  typedef struct packed {
    logic match;
  } t16d_cmp_st_t;

endpackage

// file: verilog/t16d_capt.sv
// capture input: source select, noise filter and edge detector
`timescale 1ns/1ps
`default_nettype none
`include "t16d_cfg.svh"

module t16d_capt
  import t16d_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // sources
  input wire logic pin,
  input wire logic acmp,
  input wire logic src_sel,
  // configuration
  input wire logic edge_sel,
  input wire logic filt_en,
  // event
  output logic evt
);

  t16d_capt_st_t st_ff;
  t16d_capt_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.hist = {st_ff.hist[2:0], src_sel ? acmp : pin};
    if (filt_en) begin
      // output moves only after four equal samples in a row
      if (&st_ff.hist[`T16D_FILT_LEN-1:0]) begin
        nxt_st.filt = 1'b1;
      end else if (~|st_ff.hist[`T16D_FILT_LEN-1:0]) begin
        nxt_st.filt = 1'b0;
      end
    end else begin
      nxt_st.filt = st_ff.hist[0];
    end
    nxt_st.prev = st_ff.filt;
    // one means rising, zero means falling
    nxt_st.evt = edge_sel ? (st_ff.filt & ~st_ff.prev) : (~st_ff.filt & st_ff.prev);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign evt = st_ff.evt;

endmodule // t16d_capt
`default_nettype wire

// file: verilog/t16d_cmp.sv
// one compare unit: registered equality on each timer tick
`timescale 1ns/1ps
`default_nettype none

module t16d_cmp
  import t16d_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // timing
  input wire logic tick,
  input wire logic block,
  // values
  input wire logic [15:0] cnt,
  input wire logic [15:0] cmp_val,
  // result
  output logic match
);

  t16d_cmp_st_t st_ff;
  t16d_cmp_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    // registered so the match shows the cycle after equality
    nxt_st.match = tick & ~block & (cnt == cmp_val);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign match = st_ff.match;

endmodule // t16d_cmp
`default_nettype wire

// file: test/t16d_properties.sv
// port-level assertions for the 16-bit timer data block
`timescale 1ns/1ps
`default_nettype none

module t16d_properties (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // cpu byte bus
  input wire logic [7:0] IO_ADDR,
  input wire logic IO_WR,
  input wire logic IO_RD,
  input wire logic [7:0] IO_RDATA,
  // timer control and flag clearing
  input wire logic TIMER_TICK,
  input wire logic GLOBAL_IRQ_ENABLE,
  input wire logic CAPTURE_FLAG_CLEAR,
  input wire logic MATCH_B_FLAG_CLEAR,
  input wire logic CAPTURE_IRQ_ACK,
  input wire logic MATCH_B_IRQ_ACK,
  // results
  input wire logic WAVEFORM_MATCH_A,
  input wire logic WAVEFORM_MATCH_B,
  input wire logic CAPTURE_FLAG,
  input wire logic MATCH_B_FLAG,
  input wire logic CAPTURE_IRQ_REQ,
  input wire logic MATCH_B_IRQ_REQ
);
  default clocking @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);

  // =====
  // compare path
  a_match_b_flag: assert property (WAVEFORM_MATCH_B |=> MATCH_B_FLAG)
    else $error("match b strobe not followed by its flag");
  a_flag_from_match: assert property ($rose(MATCH_B_FLAG) |-> $past(WAVEFORM_MATCH_B))
    else $error("match b flag rose without a match");
  a_match_b_sticky: assert property (
    MATCH_B_FLAG && !MATCH_B_FLAG_CLEAR && !MATCH_B_IRQ_ACK |=> MATCH_B_FLAG)
    else $error("match b flag dropped without a clear");
  a_write_blocks: assert property (
    IO_WR && IO_ADDR == 8'h84 ##1 TIMER_TICK |=> !WAVEFORM_MATCH_A && !WAVEFORM_MATCH_B)
    else $error("match seen on the tick after a counter write");

  // =====
  // capture flag and interrupt gating
  a_cap_flag_fall: assert property (
    $fell(CAPTURE_FLAG) |-> $past(CAPTURE_FLAG_CLEAR) || $past(CAPTURE_IRQ_ACK))
    else $error("capture flag cleared by itself");
  a_cap_irq_gate: assert property (
    CAPTURE_IRQ_REQ |-> $past(CAPTURE_FLAG) && $past(GLOBAL_IRQ_ENABLE))
    else $error("capture request without flag or global enable");
  a_mb_irq_gate: assert property (
    MATCH_B_IRQ_REQ |-> $past(MATCH_B_FLAG) && $past(GLOBAL_IRQ_ENABLE))
    else $error("match b request without flag or global enable");

  // =====
  // byte bus
  a_rdata_hold: assert property (!$past(IO_RD) |-> $stable(IO_RDATA))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (IO_RD && IO_ADDR == 8'h70 |=> IO_RDATA == 8'h00)
    else $error("unmapped read not zero");
endmodule // t16d_properties

`default_nettype wire

// file: test/t16d_cpu.sv
// cpu side of the byte bus: strobed byte and 16-bit transfers
`timescale 1ns/1ps
`default_nettype none

module t16d_cpu (
  // clock
  input wire logic clk,
  // byte bus
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [7:0] rdata
);
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end

  // =====
  // one strobe cycle per byte, off the falling edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = w;
    rd = !w;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b0;
    // released bus shows no stale address or data
    addr = ~a;
    wdata = ~d;
    q = rdata;
  endtask

  // high byte first: the latch must hold it when the low byte commits
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    logic [7:0] q;
    xfer(1'b1, a + 8'h01, v[15:8], q);
    xfer(1'b1, a, v[7:0], q);
  endtask

  // low byte first: the high byte then comes from the snapshot
  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    xfer(1'b0, a, 8'h00, v[7:0]);
    xfer(1'b0, a + 8'h01, 8'h00, v[15:8]);
  endtask
endmodule // t16d_cpu

`default_nettype wire

// file: test/tb.sv
// self-checking bench for the 16-bit timer data block
`timescale 1ns/1ps
`default_nettype none

bind t16d_top t16d_properties u_props (.CORE_CLK, .RST_N, .IO_ADDR, .IO_WR, .IO_RD,
  .IO_RDATA, .TIMER_TICK, .GLOBAL_IRQ_ENABLE, .CAPTURE_FLAG_CLEAR, .MATCH_B_FLAG_CLEAR,
  .CAPTURE_IRQ_ACK, .MATCH_B_IRQ_ACK, .WAVEFORM_MATCH_A, .WAVEFORM_MATCH_B,
  .CAPTURE_FLAG, .MATCH_B_FLAG, .CAPTURE_IRQ_REQ, .MATCH_B_IRQ_REQ);

module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic tick = 1'b0;
  logic [3:0] mode = 4'h0;
  logic esel = 1'b1, filt = 1'b0, src = 1'b0, gie = 1'b1, pin = 1'b0, cmpo = 1'b0;
  logic cf_clr = 1'b0, mb_clr = 1'b0, cf_ack = 1'b0, mb_ack = 1'b0, ex;
  logic [7:0] addr, wdata, rdata, len;
  logic wr, rd, ma, mb, cf, mbf, cirq, mirq;
  logic [15:0] v, x;
  // {source, edge, filter, expect} nibble, mode, pulse length
  logic [15:0] ctab [9] = '{16'h5014, 16'h1014, 16'hd014, 16'h6002, 16'h7008,
                            16'h4c14, 16'h4814, 16'h4a14, 16'h4e14};
  int seed = 35, miscompares = 0, check_count = 0, tmode = 0;
  int m_cnt, m_a, m_b, m_tmp, m_cap;
  logic m_blk, e_a, e_b, m_ie, m_fb, m_ib;

  always #2 clk = ~clk;

  t16d_cpu u_cpu (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

  t16d_top u_dut (
    .CORE_CLK(clk), .RST_N(rst_n), .IO_ADDR(addr), .IO_WDATA(wdata), .IO_WR(wr), .IO_RD(rd),
    .IO_RDATA(rdata), .TIMER_TICK(tick), .WAVEFORM_MODE_SELECT(mode),
    .CAPTURE_EDGE_SELECT(esel), .CAPTURE_NOISE_FILTER_ENABLE(filt),
    .CAPTURE_FROM_COMPARATOR(src), .GLOBAL_IRQ_ENABLE(gie), .CAPTURE_INPUT_PIN(pin),
    .COMPARATOR_OUT(cmpo), .CAPTURE_FLAG_CLEAR(cf_clr), .MATCH_B_FLAG_CLEAR(mb_clr),
    .CAPTURE_IRQ_ACK(cf_ack), .MATCH_B_IRQ_ACK(mb_ack), .WAVEFORM_MATCH_A(ma),
    .WAVEFORM_MATCH_B(mb), .CAPTURE_FLAG(cf), .MATCH_B_FLAG(mbf), .CAPTURE_IRQ_REQ(cirq),
    .MATCH_B_IRQ_REQ(mirq));

  // =====
  // reference model of counter, compares and match-b flag, snooping the bus
  always @(posedge clk) begin
    if (!rst_n) begin
      {m_blk, e_a, e_b, m_ie, m_fb, m_ib} = '0;
      m_cnt = 0;
      m_a = 0;
      m_b = 0;
      m_tmp = 0;
      m_cap = 0;
    end else begin
      m_ib = m_ie && gie && m_fb;
      m_fb = e_b || (m_fb && !mb_clr && !mb_ack);
      e_a = tick && !m_blk && m_cnt == m_a;
      e_b = tick && !m_blk && m_cnt == m_b;
      if (tick) begin
        m_blk = 1'b0;
        if (mode[3] && !mode[0] && m_cnt == m_cap) m_cnt = 0;
        else m_cnt = (m_cnt + 1) % 65536;
      end
      if (wr && addr == 8'h86) m_cap = m_tmp * 256 + wdata;
      if (wr && addr[7:4] == 4'h8 && addr[0]) m_tmp = wdata;
      if (wr && addr == 8'h6f) m_ie = wdata[2];
      if (wr && addr == 8'h84) begin
        m_cnt = m_tmp * 256 + wdata;
        m_blk = 1'b1;
      end
      if (wr && addr == 8'h88) m_a = m_tmp * 256 + wdata;
      if (wr && addr == 8'h8a) m_b = m_tmp * 256 + wdata;
    end
  end

  // random ticks, clears and global enable reach the design
  always @(negedge clk) begin
    tick <= tmode == 2 || (tmode == 1 && $random(seed) % 2 == 0);
    mb_clr <= $random(seed) % 16 == 0;
    mb_ack <= $random(seed) % 16 == 0;
    // enable returns high on its own once ticks stop; no second driver
    gie <= tmode == 0 || $random(seed) % 4 != 0;
    if (rst_n) begin
      chk(ma, e_a);
      chk(mb, e_b);
      chk(mbf, m_fb);
      chk(mirq, m_ib);
    end
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // =====
  // main sequence
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 4; i++) begin
      u_cpu.rd16(8'h84 + 8'(2 * i), v);
      chk(v, 16'h0000);
      x = 16'($random(seed));
      u_cpu.wr16(8'h84 + 8'(2 * i), x);
      u_cpu.rd16(8'h84 + 8'(2 * i), v);
      chk(v, x);
    end
    u_cpu.xfer(1'b1, 8'h6f, 8'hff, v[7:0]);
    u_cpu.xfer(1'b0, 8'h6f, 8'h00, v[7:0]);
    chk(v[7:0], 8'h24);
    u_cpu.xfer(1'b0, 8'h70, 8'h00, v[7:0]);
    chk(v[7:0], 8'h00);
    // one latch for all pairs: a high read returns the last snapshot
    u_cpu.wr16(8'h88, 16'h5a3c);
    u_cpu.xfer(1'b0, 8'h88, 8'h00, v[7:0]);
    u_cpu.xfer(1'b0, 8'h8b, 8'h00, v[15:8]);
    chk(v, 16'h5a3c);
    u_cpu.xfer(1'b1, 8'h89, 8'h77, v[7:0]);
    u_cpu.xfer(1'b1, 8'h8a, 8'h11, v[7:0]);
    u_cpu.rd16(8'h8a, v);
    chk(v, 16'h7711);
    for (int j = 0; j < 4; j++) begin
      x = 16'($random(seed));
      u_cpu.wr16(8'h88, x + 16'h000c);
      u_cpu.wr16(8'h8a, x + 16'h0014);
      u_cpu.wr16(8'h84, x);
      tmode = 1;
      repeat (60) @(negedge clk);
      tmode = 0;
    end
    // counter lands on compare b with ticks every cycle
    tmode = 2;
    u_cpu.wr16(8'h84, x + 16'h0014);
    repeat (30) @(negedge clk);
    tmode = 0;
    for (int i = 0; i < 9; i++) begin
      {src, esel, filt, ex, mode, len} = ctab[i];
      pin = !esel;
      cmpo = !esel;
      repeat (12) @(negedge clk);
      cf_clr = 1'b1;
      @(negedge clk);
      cf_clr = 1'b0;
      x = 16'($random(seed));
      u_cpu.wr16(8'h84, x);
      if (src) cmpo = esel;
      else pin = esel;
      repeat (len) @(negedge clk);
      pin = !esel;
      cmpo = !esel;
      repeat (12) @(negedge clk);
      chk(cf, ex);
      chk(cirq, ex);
      u_cpu.rd16(8'h86, v);
      if (ex) chk(v, x);
      cf_ack = 1'b1;
      @(negedge clk);
      cf_ack = 1'b0;
      @(negedge clk);
      chk(cf, 1'b0);
    end
    // capture register as top: counter wraps to zero and raises the capture flag
    u_cpu.wr16(8'h86, 16'h0010);
    u_cpu.wr16(8'h84, 16'h000c);
    tmode = 2;
    repeat (8) @(negedge clk);
    tmode = 0;
    repeat (2) @(negedge clk);
    chk(cf, 1'b1);
    u_cpu.rd16(8'h84, v);
    chk(v, 16'(m_cnt));
    mode = 4'h0;
    rst_n = 1'b0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    u_cpu.rd16(8'h84, v);
    chk(v, 16'h0000);
    results;
  end

  // hang guard
  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    results;
  end
endmodule // tb

`default_nettype wire
